// ---- acr_adc_ctrl.v ----
`timescale 1ns/10ps
`include "acr_map.vh"
module acr_adc_ctrl #(
  parameter NUM_CH = `ACR_NUM_CHANNELS,
  parameter RES_BITS = `ACR_RESULT_BITS,
  parameter CONV_TAD = `ACR_CONV_TAD,
  parameter TAD_CYCLES = `ACR_TAD_CYCLES
)(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [RES_BITS-1:0] core_result,
  output reg core_enable,
  output reg core_sample,
  output reg [NUM_CH-1:0] channel_route,
  output reg [1:0] reference_select,
  output reg [NUM_CH-1:0] pin_is_analog,
  output reg conversion_done_irq
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;
  reg [7:0] conversion_control;
  reg [7:0] reference_and_pin_config;
  reg [7:0] timing_and_format_config;
  reg [7:0] result_high;
  reg [7:0] result_low;
  reg irq_status;
  reg irq_mask;
  reg state;
  reg [7:0] tad_count;
  reg [7:0] bit_count;
  wire access = psel && penable && !pready;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire conv_end;
  wire [3:0] channel_select = conversion_control[`ACR_CHS_MSB:`ACR_CHS_LSB];
  wire [3:0] pin_role_select = reference_and_pin_config[`ACR_PIN_ROLE_SELECT_MSB:`ACR_PIN_ROLE_SELECT_LSB];
  wire [15:0] right_just = {{(16-RES_BITS){1'b0}}, core_result};
  wire [15:0] left_just = {core_result, {(16-RES_BITS){1'b0}}};
  wire [15:0] placed;
  reg [31:0] next_prdata;
  reg map_hit;
  wire wr_conv;
  wire wr_ref_pin;
  wire wr_timing;
  wire wr_irq_status;
  wire wr_irq_mask;
  wire conv_abort;

  // Codes above the last implemented one leave every route line low.
  function channel_on;
    input [3:0] code;
    input integer idx;
    begin
      channel_on = (code == idx[3:0]) && (idx < NUM_CH);
    end
  endfunction

  // Register write strobes share one decode so every register sees the
  // same access qualification.
  function wr_hit;
    input strobe;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      wr_hit = strobe && (addr == ofs);
    end
  endfunction

  assign placed = timing_and_format_config[`ACR_BIT_JUSTIFY] ?
                  right_just : left_just;
  assign wr_conv = wr_hit(wr, paddr, `ACR_OFS_CONV_CTRL);
  assign wr_ref_pin = wr_hit(wr, paddr, `ACR_OFS_REF_PIN);
  assign wr_timing = wr_hit(wr, paddr, `ACR_OFS_TIMING);
  assign wr_irq_status = wr_hit(wr, paddr, `ACR_OFS_IRQ_STATUS);
  assign wr_irq_mask = wr_hit(wr, paddr, `ACR_OFS_IRQ_MASK);
  // Turning the module off wins over a conversion that would finish in
  // the same cycle, so an abort never raises the done flag.
  assign conv_abort = (state == ST_CONV) &&
                      (!conversion_control[`ACR_BIT_ENABLE] ||
                       (wr_conv && !pwdata[`ACR_BIT_ENABLE]));
  assign conv_end = (state == ST_CONV) && !conv_abort &&
                    (bit_count == CONV_TAD - 1) &&
                    (tad_count == TAD_CYCLES - 1);

  always @*
  begin
    next_prdata = 32'h00000000;
    map_hit = 1'b1;
    case (paddr)
      `ACR_OFS_CONV_CTRL:
        next_prdata = {24'h000000, conversion_control & `ACR_CONV_MASK};
      `ACR_OFS_REF_PIN:
        next_prdata = {24'h000000,
                       reference_and_pin_config & `ACR_REFPIN_MASK};
      `ACR_OFS_TIMING:
        next_prdata = {24'h000000,
                       timing_and_format_config & `ACR_TIMING_MASK};
      `ACR_OFS_RES_HIGH:
        next_prdata = {24'h000000, result_high};
      `ACR_OFS_RES_LOW:
        next_prdata = {24'h000000, result_low};
      `ACR_OFS_IRQ_STATUS:
        next_prdata = {31'h00000000, irq_status};
      `ACR_OFS_IRQ_MASK:
        next_prdata = {31'h00000000, irq_mask};
      default:
        map_hit = 1'b0;
    endcase
  end

  // One wait state: pready is high in the second access cycle.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= access;
      pslverr <= access && !map_hit;
      if (rd)
        prdata <= next_prdata;
    end
  end

  // Configuration registers change only on a software write.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reference_and_pin_config <= `ACR_REFPIN_RST;
      timing_and_format_config <= `ACR_TIMING_RST;
    end
    else
    begin
      if (wr_ref_pin)
        reference_and_pin_config <= pwdata[7:0] & `ACR_REFPIN_MASK;
      if (wr_timing)
        timing_and_format_config <= pwdata[7:0] & `ACR_TIMING_MASK;
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_status <= 1'b0;
      irq_mask <= 1'b0;
    end
    else
    begin
      if (wr_irq_mask)
        irq_mask <= pwdata[0];
      // Set wins over a write-one clear in the same cycle, so a finished
      // conversion is never lost to a late acknowledge.
      if (conv_end)
        irq_status <= 1'b1;
      else if (wr_irq_status && pwdata[0])
        irq_status <= 1'b0;
    end
  end

  // The result pair keeps its value until the next completed conversion;
  // an aborted conversion leaves it untouched.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_high <= 8'h00;
      result_low <= 8'h00;
    end
    else if (conv_end)
    begin
      result_high <= placed[15:8];
      result_low <= placed[7:0];
    end
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conversion_control <= `ACR_CONV_RST;
      state <= ST_IDLE;
      tad_count <= 8'h00;
      bit_count <= 8'h00;
    end
    else
    begin
      if (wr_conv)
      begin
        // Busy bit may only be started by software; a write clears it only by turning the module off.
        conversion_control[`ACR_CHS_MSB:`ACR_BIT_ENABLE] <=
          {pwdata[`ACR_CHS_MSB:`ACR_CHS_LSB],
           conversion_control[`ACR_BIT_GO] |
           (pwdata[`ACR_BIT_GO] & pwdata[`ACR_BIT_ENABLE]),
           pwdata[`ACR_BIT_ENABLE]};
        conversion_control[7:6] <= 2'b00;
      end
      // The step counters run only while converting; idle clears them so
      // every start begins again at the first bit.
      case (state)
        ST_IDLE:
        begin
          tad_count <= 8'h00;
          bit_count <= 8'h00;
          if (conversion_control[`ACR_BIT_GO] &&
              conversion_control[`ACR_BIT_ENABLE])
            state <= ST_CONV;
        end
        ST_CONV:
        begin
          if (conv_abort)
          begin
            // Turning the module off abandons the conversion unfinished.
            state <= ST_IDLE;
            conversion_control[`ACR_BIT_GO] <= 1'b0;
          end
          else if (conv_end)
          begin
            state <= ST_IDLE;
            conversion_control[`ACR_BIT_GO] <= 1'b0;
          end
          else if (tad_count == TAD_CYCLES - 1)
          begin
            tad_count <= 8'h00;
            bit_count <= bit_count + 8'h01;
          end
          else
            tad_count <= tad_count + 8'h01;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi = gi + 1)
    begin : g_ch
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          channel_route[gi] <= 1'b0;
          pin_is_analog[gi] <= 1'b1;
        end
        else
        begin
          channel_route[gi] <= channel_on(channel_select, gi);
          // Code c (c>=4) turns inputs 15-c .. 11 digital.
          pin_is_analog[gi] <= (pin_role_select < 4'h4) ||
                               (gi < (15 - pin_role_select));
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_enable <= 1'b0;
      core_sample <= 1'b0;
      reference_select <= 2'b00;
      conversion_done_irq <= 1'b0;
    end
    else
    begin
      core_enable <= conversion_control[`ACR_BIT_ENABLE];
      // Sampling stops while the conversion runs, resumes after it.
      core_sample <= conversion_control[`ACR_BIT_ENABLE] &&
                     (state == ST_IDLE);
      reference_select <=
        reference_and_pin_config[`ACR_REF_MSB:`ACR_REF_LSB];
      conversion_done_irq <= (irq_status | conv_end) & irq_mask;
    end
  end
endmodule // acr_adc_ctrl

// ---- acr_adc_ctrl_asserts.sv ----
`timescale 1ns/10ps
module acr_adc_ctrl_asserts #(
  parameter NUM_CH = 12,
  parameter CONV_TAD = 13,
  parameter TAD_CYCLES = 2
)(
  input wire pclk,
  input wire presetn,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire core_enable,
  input wire core_sample,
  input wire [NUM_CH-1:0] channel_route,
  input wire [1:0] reference_select,
  input wire [NUM_CH-1:0] pin_is_analog
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_ok = pready && pwrite;
  // Counts enabled cycles with sampling stopped: one conversion's length.
  logic [7:0] low_run;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      low_run <= 8'h00;
    else if (!core_enable || core_sample)
      low_run <= 8'h00;
    else
      low_run <= low_run + 8'h01;
  a_route_onehot: assert property ($onehot0(channel_route))
    else $error("channel route not one-hot");
  a_route_none: assert property (wr_ok && paddr == 12'h000 &&
    pwdata[5:4] == 2'b11 |=> channel_route == 0)
    else $error("unused code routes an input");
  a_ref_follow: assert property (wr_ok && paddr == 12'h004 |=>
    reference_select == $past(pwdata[5:4]))
    else $error("reference select wrong");
  a_pin_therm: assert property (
    ((pin_is_analog + 1'b1) & pin_is_analog) == 0)
    else $error("analog pins not contiguous");
  a_pin_all: assert property (wr_ok && paddr == 12'h004 &&
    pwdata[3:0] < 4'h4 |=> &pin_is_analog)
    else $error("low pin code not all analog");
  a_top_zero: assert property (pready && !pwrite &&
    paddr <= 12'h004 |-> prdata[31:6] == 0)
    else $error("unimplemented bits read set");
  a_sample_idle: assert property (core_sample |-> core_enable)
    else $error("sampling while disabled");
  a_busy_read: assert property (pready && !pwrite &&
    paddr == 12'h000 && core_enable && !core_sample |-> prdata[1])
    else $error("busy bit low during conversion");
  a_enable_bit: assert property (wr_ok && paddr == 12'h000 |=>
    core_enable == $past(pwdata[0]))
    else $error("enable does not follow write");
  a_conv_len: assert property ($rose(core_sample) &&
    $past(core_enable) && core_enable |->
    low_run == CONV_TAD * TAD_CYCLES)
    else $error("conversion length wrong");
endmodule // acr_adc_ctrl_asserts
bind acr_adc_ctrl acr_adc_ctrl_asserts #(.NUM_CH(NUM_CH),
  .CONV_TAD(CONV_TAD), .TAD_CYCLES(TAD_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .core_enable(core_enable), .core_sample(core_sample),
  .channel_route(channel_route), .reference_select(reference_select),
  .pin_is_analog(pin_is_analog));

// ---- acr_adc_ctrl_tb_top.sv ----
`timescale 1ns/10ps
module acr_adc_ctrl_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, se, core_enable, core_sample, irq;
  logic [11:0] core_result, channel_route, pin_is_analog, e;
  logic [1:0] reference_select;
  int bad_count = 0, comparisons = 0, n, k;
  acr_adc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_result(core_result), .core_enable(core_enable),
    .core_sample(core_sample), .channel_route(channel_route),
    .reference_select(reference_select), .pin_is_analog(pin_is_analog),
    .conversion_done_irq(irq));
  acr_core_model u_core (.pclk(pclk), .core_enable(core_enable),
    .channel_route(channel_route), .core_result(core_result));
  initial forever #5 pclk = ~pclk;
  task chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x)
    begin
      bad_count++;
      $display("Error at %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk) n++; while (pready !== 1'b1 && n < 20);
    if (n >= 20) bad_count++;
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Enable first, then start: setting both in one write is not relied on.
  task conv(input int ch);
    xfer(12'h000, 1'b1, 32'(ch * 4 + 1));
    xfer(12'h000, 1'b1, 32'(ch * 4 + 3));
    xfer(12'h000, 1'b0, 32'h0);
    chk(q, 32'(ch * 4 + 3));
    k = 0;
    do begin xfer(12'h000, 1'b0, 32'h0); k++; end
    while (q[1] !== 1'b0 && k < 40);
    chk(q[1], 32'h0);
    e = (ch < 12 ? 12'h001 << ch : 12'h000) ^ 12'h5a5;
    @(negedge pclk);
  endtask
  initial
  begin
    #200000;
    bad_count++;
    results;
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(12'h000, 1'b0, 32'h0); chk(q, 32'h0);
    xfer(12'h004, 1'b0, 32'h0); chk(q, 32'h0);
    chk(pin_is_analog, 32'hfff);
    xfer(12'h000, 1'b1, 32'hffffff3c); xfer(12'h000, 1'b0, 32'h0);
    chk(q, 32'h3c);
    for (int c = 0; c < 16; c++)
    begin
      xfer(12'h004, 1'b1, 32'(c + (c % 4) * 16));
      @(negedge pclk);
      chk(pin_is_analog, c < 4 ? 12'hfff : 12'hfff >> (c - 3));
      chk(reference_select, 32'(c % 4));
    end
    xfer(12'h004, 1'b1, 32'hffffffff); xfer(12'h004, 1'b0, 32'h0);
    chk(q, 32'h3f);
    xfer(12'h018, 1'b1, 32'h1);
    for (int ch = 0; ch < 16; ch++)
    begin
      conv(ch);
      chk(channel_route, ch < 12 ? 12'h001 << ch : 12'h000);
      xfer(12'h00c, 1'b0, 32'h0); chk(q, {24'h0, e[11:4]});
      xfer(12'h010, 1'b0, 32'h0); chk(q, {24'h0, e[3:0], 4'h0});
      chk(irq, 32'h1);
      xfer(12'h014, 1'b1, 32'h1);
    end
    @(negedge pclk); chk(irq, 32'h0);
    xfer(12'h018, 1'b1, 32'h0); xfer(12'h008, 1'b1, 32'hff);
    xfer(12'h008, 1'b0, 32'h0); chk(q, 32'hbf);
    conv(3);
    xfer(12'h00c, 1'b0, 32'h0); chk(q, {28'h0, e[11:8]});
    xfer(12'h010, 1'b0, 32'h0); chk(q, {24'h0, e[7:0]});
    xfer(12'h014, 1'b0, 32'h0); chk(q, 32'h1);
    chk(irq, 32'h0);
    xfer(12'h000, 1'b1, 32'h1); xfer(12'h000, 1'b1, 32'h3);
    xfer(12'h000, 1'b1, 32'h0); xfer(12'h000, 1'b0, 32'h0);
    chk(q, 32'h0);
    xfer(12'h000, 1'b1, 32'h1); xfer(12'h000, 1'b1, 32'h3);
    @(posedge pclk) presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    @(negedge pclk); chk(core_enable, 32'h0);
    xfer(12'h000, 1'b0, 32'h0); chk(q, 32'h0);
    xfer(12'h01c, 1'b0, 32'h0); chk(q, 32'h0);
    chk(se, 32'h1);
    results;
  end
endmodule // acr_adc_ctrl_tb_top

// ---- acr_core_model.sv ----
`timescale 1ns/10ps
module acr_core_model (
  input wire pclk,
  input wire core_enable,
  input wire [11:0] channel_route,
  output logic [11:0] core_result
);
  initial core_result = 12'h000;
  // An idle core toggles its output so a stale result cannot pass.
  always @(posedge pclk)
    if (core_enable)
      core_result <= channel_route ^ 12'h5a5;
    else
      core_result <= ~core_result;
endmodule // acr_core_model

// ---- acr_map.vh ----
`ifndef ACR_MAP_VH
`define ACR_MAP_VH
`define ACR_OFS_CONV_CTRL 12'h000
`define ACR_OFS_REF_PIN 12'h004
`define ACR_OFS_TIMING 12'h008
`define ACR_OFS_RES_HIGH 12'h00c
`define ACR_OFS_RES_LOW 12'h010
`define ACR_OFS_IRQ_STATUS 12'h014
`define ACR_OFS_IRQ_MASK 12'h018
`define ACR_BIT_ENABLE 0
`define ACR_BIT_GO 1
`define ACR_CHS_LSB 2
`define ACR_CHS_MSB 5
`define ACR_REF_LSB 4
`define ACR_REF_MSB 5
`define ACR_PIN_ROLE_SELECT_LSB 0
`define ACR_PIN_ROLE_SELECT_MSB 3
`define ACR_BIT_JUSTIFY 7
`define ACR_CONV_RST 8'h00
`define ACR_REFPIN_RST 8'h00
`define ACR_TIMING_RST 8'h00
`define ACR_CONV_MASK 8'h3f
`define ACR_REFPIN_MASK 8'h3f
`define ACR_TIMING_MASK 8'hbf
`define ACR_NUM_CHANNELS 12
`define ACR_RESULT_BITS 12
`define ACR_CONV_TAD 13
`define ACR_TAD_CYCLES 2
`endif
